// *** rtl/sps_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module sps_ctrl (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit pattern generator
    output logic [1:0] tx_pattern_sel,
    output logic [2:0] tx_mode,
    output logic tx_level_b,
    // Receive datapath status
    input wire logic [2:0] rx_mode_in,
    input wire logic rx_level_b_in,
    input wire logic rx_locked_in,
    input wire logic rx_crc_err,
    input wire logic rx_edh_err,
    input wire logic rx_rate_change,
    input wire logic [31:0] rx_pid_in,
    input wire logic rx_pid_valid_in,
    // Receive change sequence from the transceiver controller
    input wire logic rx_chg_start,
    input wire logic rx_chg_ok,
    input wire logic rx_chg_err,
    input wire logic [3:0] rx_chg_code,
    input wire logic rx_gt_reset_done,
    // Receive status outputs
    output logic rx_error,
    output logic [sps_pkg::ERR_CNT_W-1:0] rx_err_count,
    output logic rx_level_b,
    output logic rx_locked,
    output logic [31:0] rx_pid,
    output logic rx_pid_valid,
    output logic rx_change_done,
    output logic rx_change_fail,
    output logic [3:0] rx_fail_code,
    output logic rx_reset_done,
    output logic rx_ctrl_reset
);
    // Register state
    logic [1:0] pat_req_r;
    logic [2:0] mode_r;
    logic [1:0] pat_r;
    logic [2:0] txmode_r;
    logic txlb_r;
    logic err_r;
    logic lb_r;
    logic lock_r;
    logic [31:0] pid_r;
    logic pidv_r;
    logic rstd_r;
    logic crst_r;
    logic [3:0] code_r;
    logic done_r;
    logic fail_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    sps_pkg::sps_chg_e chg_r;
    sps_pkg::sps_chg_e chg_nxt;
    logic [sps_pkg::ERR_CNT_W-1:0] cnt;

    // Map the requested pattern onto the generator for the current mode
    function automatic logic [1:0] pat_map(input logic [1:0] sel, input logic [2:0] mode);
        logic [1:0] res;
        res = sps_pkg::PAT_CHECKFIELD;
        if (sel[0]) begin
            res = sps_pkg::PAT_CHECKFIELD;
        end else if (mode == sps_pkg::MODE_SD) begin
            res = sps_pkg::PAT_BARS_SD;
        end else if (sel[1]) begin
            res = sps_pkg::PAT_BARS_75;
        end else begin
            res = sps_pkg::PAT_BARS_FULL;
        end
        return res;
    endfunction

    // Bus decode; the slave answers in the second access cycle, after one wait state
    wire acc = psel && penable && !pready_r;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_txc = (paddr == sps_pkg::OFS_TX_CTRL);
    wire hit_rxc = (paddr == sps_pkg::OFS_RX_CTRL);
    wire hit_rxs = (paddr == sps_pkg::OFS_RX_STAT);
    wire hit_cnt = (paddr == sps_pkg::OFS_ERR_CNT);
    wire hit_pid = (paddr == sps_pkg::OFS_PAYLOAD);
    wire hit_txs = (paddr == sps_pkg::OFS_TX_STAT);
    wire mapped = hit_txc | hit_rxc | hit_rxs | hit_cnt | hit_pid | hit_txs;

    wire [2:0] wmode = pwdata[sps_pkg::TXC_MODE_LSB +: 3];
    // Only HD, SD, 3G-A and the extra 3G-B code are legal; others are ignored
    wire wmode_ok = (wmode <= sps_pkg::MODE_3GB);
    wire err_clr = wr && hit_rxc && pwdata[sps_pkg::RXC_ERR_CLR];
    wire ctl_rst = wr && hit_rxc && pwdata[sps_pkg::RXC_CTRL_RST];
    // SD counts EDH, HD and 3G count CRC
    wire sd_rx = (rx_mode_in == sps_pkg::MODE_SD);
    wire cnt_inc = sd_rx ? rx_edh_err : rx_crc_err;
    wire any_err = rx_crc_err | rx_edh_err;

    always_comb begin
        chg_nxt = chg_r;
        if (rx_chg_start) begin
            chg_nxt = sps_pkg::SPS_CHG_BUSY;
        end else begin
            unique case (chg_r)
                sps_pkg::SPS_CHG_IDLE,
                sps_pkg::SPS_CHG_DONE,
                sps_pkg::SPS_CHG_FAIL: begin
                    chg_nxt = chg_r;
                end
                sps_pkg::SPS_CHG_BUSY: begin
                    if (rx_chg_err) begin
                        chg_nxt = sps_pkg::SPS_CHG_FAIL;
                    end else if (rx_chg_ok) begin
                        chg_nxt = sps_pkg::SPS_CHG_DONE;
                    end
                end
            endcase
        end
    end

    wire [31:0] rxs_word = {16'h0000, 4'h0, code_r,
                            1'b0, rstd_r, fail_r, done_r,
                            pidv_r, lb_r, lock_r, err_r};
    wire [31:0] cnt_word = {{(32 - sps_pkg::ERR_CNT_W){1'b0}}, cnt};
    wire [31:0] txc_word = {25'h0000000, mode_r, 2'h0, pat_req_r};
    wire [31:0] txs_word = {25'h0000000, txmode_r, 1'b0, txlb_r, pat_r};
    wire [31:0] rd_word = hit_txc ? txc_word :
                          hit_rxs ? rxs_word :
                          hit_cnt ? cnt_word :
                          hit_pid ? (pidv_r ? pid_r : 32'h00000000) :
                          hit_txs ? txs_word : 32'h00000000;

    sps_err_counter u_cnt (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .clr(err_clr || rx_rate_change),
        .inc(cnt_inc && rx_locked_in),
        .count(cnt)
    );

    // Bus answer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else if (ce) begin
            pready_r <= acc;
            pslverr_r <= acc && !mapped;
            prdata_r <= rd ? rd_word : 32'h00000000;
        end
    end

    // Transmit control
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pat_req_r <= sps_pkg::TX_PAT_RST;
            mode_r <= sps_pkg::TX_MODE_RST;
            pat_r <= sps_pkg::PAT_BARS_FULL;
            txmode_r <= sps_pkg::TX_MODE_RST;
            txlb_r <= 1'b0;
        end else if (ce) begin
            if (wr && hit_txc) begin
                pat_req_r <= pwdata[sps_pkg::TXC_PAT_LSB +: 2];
                if (wmode_ok) begin
                    mode_r <= wmode;
                end
            end
            pat_r <= pat_map(pat_req_r, mode_r);
            txmode_r <= mode_r;
            txlb_r <= (mode_r == sps_pkg::MODE_3GB);
        end
    end

    // Receive status; errors in the same cycle as a clear keep the flag set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            err_r <= 1'b0;
            lb_r <= 1'b0;
            lock_r <= 1'b0;
            pid_r <= 32'h00000000;
            pidv_r <= 1'b0;
            rstd_r <= 1'b0;
            crst_r <= 1'b0;
            code_r <= 4'h0;
            chg_r <= sps_pkg::SPS_CHG_IDLE;
            done_r <= 1'b0;
            fail_r <= 1'b0;
        end else if (ce) begin
            err_r <= any_err || (err_r && !err_clr);
            lb_r <= rx_level_b_in && rx_locked_in;
            lock_r <= rx_locked_in;
            pid_r <= rx_pid_in;
            pidv_r <= rx_pid_valid_in && rx_locked_in;
            rstd_r <= rx_gt_reset_done;
            crst_r <= ctl_rst;
            chg_r <= chg_nxt;
            // Decoded from the next state so the flags stay in step with the state register
            done_r <= (chg_nxt == sps_pkg::SPS_CHG_DONE);
            fail_r <= (chg_nxt == sps_pkg::SPS_CHG_FAIL);
            if (chg_r == sps_pkg::SPS_CHG_BUSY && rx_chg_err && !rx_chg_start) begin
                code_r <= rx_chg_code;
            end else if (rx_chg_start) begin
                code_r <= 4'h0;
            end
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign tx_pattern_sel = pat_r;
    assign tx_mode = txmode_r;
    assign tx_level_b = txlb_r;
    assign rx_error = err_r;
    assign rx_err_count = cnt;
    assign rx_level_b = lb_r;
    assign rx_locked = lock_r;
    assign rx_pid = pid_r;
    assign rx_pid_valid = pidv_r;
    assign rx_change_done = done_r;
    assign rx_change_fail = fail_r;
    assign rx_fail_code = code_r;
    assign rx_reset_done = rstd_r;
    assign rx_ctrl_reset = crst_r;
endmodule
`default_nettype wire

// *** rtl/sps_err_counter.sv ***
`timescale 1ns/1ps
`default_nettype none
module sps_err_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Control
    input wire logic clr,
    input wire logic inc,
    // Count
    output logic [sps_pkg::ERR_CNT_W-1:0] count
);
    logic [sps_pkg::ERR_CNT_W-1:0] cnt_r;
    wire at_max = (cnt_r == sps_pkg::ERR_CNT_MAX);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= sps_pkg::ERR_CNT_RST;
        end else if (ce) begin
            if (clr) begin
                cnt_r <= sps_pkg::ERR_CNT_RST;
            end else if (inc && !at_max) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    assign count = cnt_r;
endmodule
`default_nettype wire

// *** rtl/sps_pkg.sv ***
// Overview of operation
// - In HD and 3G modes pattern select 0 gives full-field bars, 1 and 3 the checkfield, 2 the 75% bars.
// - In SD mode pattern select 0 and 2 give SD colour bars, 1 and 3 give the checkfield.
// - The transmit mode selector also accepts code 3'b011, which streams 3G Level B patterns.
// - The receive error flag sets on any CRC or EDH error and holds until an error clear.
// - While the receiver is locked, the error counter counts CRC errors in HD and 3G modes and EDH errors in SD mode only.
// - An error clear zeroes the error counter as well as the sticky flag.
// - A bit-rate change that forces a re-lock clears the counter early in the lock process.
// - The Level B indication is high only while a 3G Level B signal is received.
// - The locked status is high while the receiver is locked and low otherwise.
// - The four payload identifier bytes are presented, valid only while the payload valid flag is high.
// - Each receive change sequence ends in change-done, or in change-fail with a cause code.
// - Receive reset-done goes high once the transceiver receive reset sequence completes.
// - The receive controller reset input starts the receive controller reset routine.
package sps_pkg;

    // Transmit and receive mode codes
    localparam logic [2:0] MODE_HD = 3'h0;
    localparam logic [2:0] MODE_SD = 3'h1;
    localparam logic [2:0] MODE_3GA = 3'h2;
    localparam logic [2:0] MODE_3GB = 3'h3;

    // Pattern generator selections
    localparam logic [1:0] PAT_BARS_FULL = 2'h0;
    localparam logic [1:0] PAT_CHECKFIELD = 2'h1;
    localparam logic [1:0] PAT_BARS_75 = 2'h2;
    localparam logic [1:0] PAT_BARS_SD = 2'h3;

    localparam int ERR_CNT_W = 24;
    localparam logic [23:0] ERR_CNT_MAX = 24'hFFFFFF;
    localparam logic [23:0] ERR_CNT_RST = 24'h000000;

    // Register offsets
    localparam logic [11:0] OFS_TX_CTRL = 12'h000;
    localparam logic [11:0] OFS_RX_CTRL = 12'h004;
    localparam logic [11:0] OFS_RX_STAT = 12'h008;
    localparam logic [11:0] OFS_ERR_CNT = 12'h00C;
    localparam logic [11:0] OFS_PAYLOAD = 12'h010;
    localparam logic [11:0] OFS_TX_STAT = 12'h014;

    // TX_CTRL field positions
    localparam int TXC_PAT_LSB = 0;
    localparam int TXC_MODE_LSB = 4;
    // RX_CTRL bit positions (write-one pulses)
    localparam int RXC_ERR_CLR = 0;
    localparam int RXC_CTRL_RST = 1;
    // RX_STAT bit positions
    localparam int RXS_ERR = 0;
    localparam int RXS_LOCKED = 1;
    localparam int RXS_LEVEL_B = 2;
    localparam int RXS_PID_VALID = 3;
    localparam int RXS_DONE = 4;
    localparam int RXS_FAIL = 5;
    localparam int RXS_RST_DONE = 6;
    localparam int RXS_CODE_LSB = 8;

    localparam logic [1:0] TX_PAT_RST = 2'h0;
    localparam logic [2:0] TX_MODE_RST = 3'h0;

    typedef enum logic [1:0] {
        SPS_CHG_IDLE = 2'b00,
        SPS_CHG_BUSY = 2'b01,
        SPS_CHG_DONE = 2'b10,
        SPS_CHG_FAIL = 2'b11
    } sps_chg_e;

endpackage

// *** testbench/sdi_pattern_and_rx_status_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdi_pattern_and_rx_status_test;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, err_seen, tx_level_b, rx_ctrl_reset;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rx_pid_in, rx_pid, txe;
    logic ce, rx_error, rx_level_b, rx_locked, rx_pid_valid, rx_change_done, rx_change_fail;
    logic rx_reset_done;
    logic [3:0] rx_fail_code;
    logic [sps_pkg::ERR_CNT_W-1:0] rx_err_count;
    logic [1:0] tx_pattern_sel, pat;
    logic [2:0] tx_mode, rx_mode_in;
    logic rx_level_b_in, rx_locked_in, rx_crc_err, rx_edh_err, rx_rate_change, rx_pid_valid_in;
    logic rx_chg_start, rx_chg_ok, rx_chg_err, rx_gt_reset_done;
    logic [3:0] rx_chg_code;
    int bad_count = 0;
    int n_tests = 0;
    sps_ctrl u_sps_ctrl (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tx_pattern_sel, .tx_mode, .tx_level_b, .rx_mode_in,
        .rx_level_b_in, .rx_locked_in, .rx_crc_err, .rx_edh_err, .rx_rate_change, .rx_pid_in,
        .rx_pid_valid_in, .rx_chg_start, .rx_chg_ok, .rx_chg_err, .rx_chg_code,
        .rx_gt_reset_done, .rx_error, .rx_err_count, .rx_level_b, .rx_locked, .rx_pid,
        .rx_pid_valid, .rx_change_done, .rx_change_fail, .rx_fail_code, .rx_reset_done,
        .rx_ctrl_reset);
    sps_rx_model u_sps_rx_model (.clk, .rx_ctrl_reset, .rx_mode_in, .rx_level_b_in,
        .rx_locked_in, .rx_crc_err, .rx_edh_err, .rx_rate_change, .rx_pid_in, .rx_pid_valid_in,
        .rx_chg_start, .rx_chg_ok, .rx_chg_err, .rx_chg_code, .rx_gt_reset_done);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err_seen = pslverr;
        check({31'h0, pready}, 32'h1);
        {psel, penable} <= 2'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // Status pins must agree with the status word read over the bus
    task automatic stchk(input logic [31:0] e);
        rdchk(sps_pkg::OFS_RX_STAT, e);
        check({20'h0, rx_fail_code, 1'b0, rx_reset_done, rx_change_fail, rx_change_done,
            rx_pid_valid, rx_level_b, rx_locked, rx_error}, e);
    endtask
    task automatic cntchk(input logic [31:0] e);
        rdchk(sps_pkg::OFS_ERR_CNT, e);
        check(32'(rx_err_count), e);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rdchk(sps_pkg::OFS_TX_CTRL, 32'h0);
        stchk(32'h40);
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 4; p++) begin
                apb(1'b1, sps_pkg::OFS_TX_CTRL, 32'(m * 16 + p));
                if (p % 2 == 1) pat = sps_pkg::PAT_CHECKFIELD;
                else if (m == 1) pat = sps_pkg::PAT_BARS_SD;
                else pat = (p == 2) ? sps_pkg::PAT_BARS_75 : sps_pkg::PAT_BARS_FULL;
                txe = {25'h0, 3'(m), 1'b0, m == 3, pat};
                rdchk(sps_pkg::OFS_TX_STAT, txe);
                check({25'h0, tx_mode, 1'b0, tx_level_b, tx_pattern_sel}, txe);
            end
        end
        apb(1'b1, sps_pkg::OFS_TX_CTRL, 32'h41);
        rdchk(sps_pkg::OFS_TX_CTRL, 32'h31);
        rdchk(12'h0FC, 32'h0);
        check({31'h0, err_seen}, 32'h1);
        u_sps_rx_model.link(sps_pkg::MODE_HD, 1'b1, 1'b0, 1'b0, 32'h0);
        repeat (3) u_sps_rx_model.errs(1'b1, 1'b0);
        repeat (2) u_sps_rx_model.errs(1'b0, 1'b1);
        cntchk(32'h3);
        stchk(32'h43);
        u_sps_rx_model.link(sps_pkg::MODE_SD, 1'b1, 1'b0, 1'b0, 32'h0);
        u_sps_rx_model.errs(1'b1, 1'b0);
        u_sps_rx_model.errs(1'b0, 1'b1);
        cntchk(32'h4);
        apb(1'b1, sps_pkg::OFS_RX_CTRL, 32'h1);
        cntchk(32'h0);
        stchk(32'h42);
        u_sps_rx_model.errs(1'b1, 1'b1);
        u_sps_rx_model.rate();
        u_sps_rx_model.errs(1'b0, 1'b1);
        cntchk(32'h1);
        // An error pulse while the clock enable is low must not be counted
        ce <= 1'b0;
        u_sps_rx_model.errs(1'b0, 1'b1);
        ce <= 1'b1;
        cntchk(32'h1);
        u_sps_rx_model.link(sps_pkg::MODE_3GB, 1'b1, 1'b1, 1'b1, 32'hA1B2C3D4);
        rdchk(sps_pkg::OFS_PAYLOAD, 32'hA1B2C3D4);
        check(rx_pid, 32'hA1B2C3D4);
        stchk(32'h4F);
        u_sps_rx_model.link(sps_pkg::MODE_HD, 1'b0, 1'b1, 1'b1, 32'h1234);
        stchk(32'h41);
        rdchk(sps_pkg::OFS_PAYLOAD, 32'h0);
        u_sps_rx_model.chg(1'b1, 4'h0);
        stchk(32'h51);
        u_sps_rx_model.chg(1'b0, 4'h9);
        stchk(32'h961);
        apb(1'b1, sps_pkg::OFS_RX_CTRL, 32'h2);
        repeat (3) @(posedge clk);
        stchk(32'h921);
        repeat (20) @(posedge clk);
        stchk(32'h961);
        // Reset again in mid-run: TX status, error count and RX status must read as after the first reset
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rdchk(sps_pkg::OFS_TX_STAT, 32'h0);
        cntchk(32'h0);
        stchk(32'h40);
        give_verdict();
    end
endmodule
`default_nettype wire

// *** testbench/sps_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sps_ctrl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Datapath
    input wire logic [2:0] tx_mode,
    input wire logic tx_level_b,
    input wire logic rx_level_b_in,
    input wire logic rx_locked_in,
    input wire logic rx_crc_err,
    input wire logic rx_edh_err,
    input wire logic rx_rate_change,
    input wire logic rx_pid_valid_in,
    input wire logic rx_chg_ok,
    input wire logic rx_error,
    input wire logic [sps_pkg::ERR_CNT_W-1:0] rx_err_count,
    input wire logic rx_level_b,
    input wire logic rx_locked,
    input wire logic rx_pid_valid,
    input wire logic rx_change_done,
    input wire logic rx_change_fail
);
    // A frozen clock enable stalls the block, so checks pause with it
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn || !ce);
    wire acc = psel && penable && !pready;
    wire clr_wr = acc && pwrite && paddr == sps_pkg::OFS_RX_CTRL && pwdata[0];
    chk_apb_answer: assert property (acc |=> pready) else $error("no bus answer");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
    chk_slverr_qual: assert property (pslverr |-> pready) else $error("stray slave error");
    chk_err_set: assert property (rx_crc_err || rx_edh_err |-> ##[1:2] rx_error)
        else $error("error flag not set");
    chk_err_sticky: assert property ($fell(rx_error) |-> $past(clr_wr))
        else $error("error flag fell alone");
    chk_cnt_step: assert property
        (rx_err_count > $past(rx_err_count) |-> rx_err_count == $past(rx_err_count) + 1)
        else $error("count jumped");
    chk_cnt_drop: assert property (rx_err_count < $past(rx_err_count) |-> rx_err_count == '0)
        else $error("count fell but not to zero");
    chk_rate_clr: assert property (rx_rate_change |-> ##[1:2] rx_err_count == '0)
        else $error("count kept over rate change");
    chk_locked_on: assert property (rx_locked_in |=> rx_locked) else $error("lock lost");
    chk_locked_off: assert property (!rx_locked_in |=> !rx_locked) else $error("false lock");
    chk_level_b_src: assert property (rx_level_b |-> $past(rx_level_b_in && rx_locked_in))
        else $error("level b without cause");
    chk_pid_gate: assert property (rx_pid_valid |-> $past(rx_pid_valid_in && rx_locked_in))
        else $error("payload valid without cause");
    chk_tx_level_b: assert property (tx_level_b == (tx_mode == sps_pkg::MODE_3GB))
        else $error("tx level b mismatch");
    chk_chg_done: assert property (rx_chg_ok |-> ##[1:2] rx_change_done && !rx_change_fail)
        else $error("change done missing");
    cover property (clr_wr);
    cover property (rx_chg_ok);
    cover property (pslverr);
endmodule
bind sps_ctrl sps_ctrl_props u_props (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .tx_mode, .tx_level_b, .rx_level_b_in, .rx_locked_in,
    .rx_crc_err, .rx_edh_err, .rx_rate_change, .rx_pid_valid_in, .rx_chg_ok, .rx_error,
    .rx_err_count, .rx_level_b, .rx_locked, .rx_pid_valid, .rx_change_done, .rx_change_fail);
`default_nettype wire

// *** testbench/sps_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sps_rx_model (
    input wire logic clk,
    input wire logic rx_ctrl_reset,
    output logic [2:0] rx_mode_in,
    output logic rx_level_b_in,
    output logic rx_locked_in,
    output logic rx_crc_err,
    output logic rx_edh_err,
    output logic rx_rate_change,
    output logic [31:0] rx_pid_in,
    output logic rx_pid_valid_in,
    output logic rx_chg_start,
    output logic rx_chg_ok,
    output logic rx_chg_err,
    output logic [3:0] rx_chg_code,
    output logic rx_gt_reset_done
);
    logic [31:0] pid_val = 32'h0;
    logic [31:0] junk = 32'h5A5A5A5A;
    logic [3:0] rst_cnt = 4'hF;
    initial {rx_mode_in, rx_level_b_in, rx_locked_in, rx_crc_err, rx_edh_err, rx_rate_change,
        rx_pid_valid_in, rx_chg_start, rx_chg_ok, rx_chg_err, rx_chg_code, rx_gt_reset_done} = '0;
    // Bytes outside a valid packet are junk, never a stale copy
    always @(posedge clk) junk <= ~junk;
    assign rx_pid_in = rx_pid_valid_in ? pid_val : junk;
    always @(posedge clk) begin
        if (rx_ctrl_reset === 1'b1) begin
            rst_cnt <= 4'hF;
        end else if (rst_cnt != 4'h0) begin
            rst_cnt <= rst_cnt - 4'h1;
        end
        rx_gt_reset_done <= rst_cnt == 4'h0;
    end
    task automatic link(input logic [2:0] m, input logic lk, lb, pv, input logic [31:0] pid);
        @(posedge clk);
        {rx_mode_in, rx_locked_in, rx_level_b_in, rx_pid_valid_in} <= {m, lk, lb, pv};
        pid_val <= pid;
    endtask
    task automatic errs(input logic crc, edh);
        @(posedge clk);
        {rx_crc_err, rx_edh_err} <= {crc, edh};
        @(posedge clk);
        {rx_crc_err, rx_edh_err} <= 2'h0;
    endtask
    task automatic rate();
        @(posedge clk);
        rx_rate_change <= 1'b1;
        @(posedge clk);
        rx_rate_change <= 1'b0;
    endtask
    task automatic chg(input logic ok, input logic [3:0] code);
        @(posedge clk);
        rx_chg_start <= 1'b1;
        @(posedge clk);
        {rx_chg_start, rx_chg_ok, rx_chg_err, rx_chg_code} <= {1'b0, ok, !ok, code};
        @(posedge clk);
        {rx_chg_ok, rx_chg_err} <= 2'h0;
    endtask
endmodule
`default_nettype wire
